//--- shared/lec_pkg.sv
// Package of constants and types for the line error counter readout block.
`default_nettype none
package lec_pkg;
  // Record layout: version word, two 16-bit counters, six 32-bit summators, 64-bit map.
  localparam logic [15:0] REC_VERSION    = 16'h0000;  // Version value, high and low byte.
  localparam int          REC_WORDS      = 10;        // Bus words that carry the record.
  localparam int          REC_BITS       = 320;       // Record padded to whole words.
  localparam int          NUM_SUMS       = 6;         // Number of 32-bit summators.
  localparam int          NUM_EVENTS     = 8;         // Number of event classes.
  // Summator slots in record order.
  localparam int          SUM_DROP       = 0;         // Slave dropout, record bytes 6 to 9.
  localparam int          SUM_MISSING    = 1;         // Missing response, bytes 10 to 13.
  localparam int          SUM_CORRUPT    = 2;         // Corrupt response, bytes 14 to 17.
  localparam int          SUM_PERIPH     = 3;         // Peripheral fault, bytes 18 to 21.
  localparam int          SUM_PROTOCOL   = 4;         // Protocol error, bytes 22 to 25.
  localparam int          SUM_BAD_MASTER = 5;         // Bad own frame, bytes 26 to 29.
  // Event bit positions in the interrupt status and mask registers.
  localparam int          EV_POWER_FAIL  = 0;         // Supply failure.
  localparam int          EV_GND_SHORT   = 1;         // Ground short.
  localparam int          EV_SUM_BASE    = 2;         // First summator event; slot i is bit 2+i.
  // Register byte offsets on the bus.
  localparam logic [7:0]  OFS_REC_FIRST  = 8'h00;     // First record word.
  localparam logic [7:0]  OFS_CTRL       = 8'h28;     // Control register.
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h2C;     // Sticky event status, cleared by read.
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h30;     // Interrupt mask.
  // Field positions.
  localparam int          CTRL_CLEAR_BIT = 0;         // Writing one clears all counters.
  // Reset values.
  localparam logic [15:0] CNT16_RST      = 16'h0000;  // Counter reset value.
  localparam logic [31:0] SUM_RST        = 32'h00000000;  // Summator reset value.
  localparam logic [63:0] MAP_RST        = 64'h0000000000000000;  // Slave map reset value.
  localparam logic [7:0]  STAT_RST       = 8'h00;     // Status reset value.
  localparam logic [7:0]  MASK_RST       = 8'h00;     // Mask reset value.
  // Timing: cycles from the taking edge to the acknowledge.
  localparam int          ACK_LATENCY    = 1;

  // Complete state of the readout block.
  typedef struct packed {
    logic [15:0]                power_cnt;  // Supply failure counter.
    logic [15:0]                gnd_cnt;    // Ground short counter.
    logic [NUM_SUMS-1:0][31:0]  sum;        // Summators in record order.
    logic [63:0]                slave_map;  // Bits 31:0 standard or A slaves, 63:32 B slaves.
    logic [NUM_EVENTS-1:0]      stat;       // Sticky event status.
    logic [NUM_EVENTS-1:0]      mask;       // Interrupt mask.
    logic                       ack;        // Bus acknowledge.
    logic [31:0]                dat;        // Bus read data.
    logic                       irq;        // Interrupt output.
  } lec_state_t;
endpackage
`default_nettype wire

//--- verilog/lec_readout.sv
// Line error counters and diagnostic record readout over a classic Wishbone slave.
`default_nettype none
module lec_readout #(
  parameter int ADR_W = 8  // Wishbone byte address width.
) (
  // Clock, reset and clock enable.
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // Wishbone classic slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Interrupt.
  output logic                  irq_o,
  // Fault events, one-cycle pulses from the line master logic.
  input  wire logic             ev_power_fail,
  input  wire logic             ev_gnd_short,
  input  wire logic             ev_slave_drop,
  input  wire logic             ev_missing,
  input  wire logic             ev_corrupt,
  input  wire logic             ev_periph,
  input  wire logic             ev_protocol,
  input  wire logic             ev_bad_master,
  // Slave error marking.
  input  wire logic             err_valid,
  input  wire logic             err_bank_b,
  input  wire logic [4:0]       err_slave
);
  import lec_pkg::*;

  // The decoder needs word address bits 7:2.
  if (ADR_W < 8) begin : g_bad_adr_w
    $error("ADR_W must be at least 8");
  end

  // The handshake below answers exactly one cycle after taking a request.
  if (ACK_LATENCY != 1) begin : g_bad_latency
    $error("ACK_LATENCY must be 1");
  end

  lec_state_t                   s_q;         // Registered state.
  lec_state_t                   s_d;         // Next state.
  logic [NUM_EVENTS-1:0]        ev;          // Events gathered in status bit order.
  logic [5:0]                   word_idx;    // Addressed bus word.
  logic [5:0]                   err_idx;     // Bit in the slave map to set.
  logic [REC_BITS-1:0]          rec_flat;    // Record, byte 0 in the top bits.
  logic [REC_WORDS-1:0][31:0]   rec_w;       // Record as words, word 0 in the top slot.
  logic                         take;        // A new request is taken this cycle.
  logic                         finish;      // The master samples ack at the coming edge.
  logic                         clr_hit;     // Clear command completes this cycle.

  // Event classes in the order of the status bits.
  assign ev = {ev_bad_master, ev_protocol, ev_periph, ev_corrupt,
               ev_missing, ev_slave_drop, ev_gnd_short, ev_power_fail};
  assign word_idx = wb_adr_i[7:2];
  // Standard or A slaves occupy map bits 0 to 31, B slaves bits 32 to 63.
  assign err_idx  = {err_bank_b, err_slave};

  // Record assembly: big-endian fields, map bytes with the lowest slave first.
  assign rec_flat = {REC_VERSION, s_q.power_cnt, s_q.gnd_cnt,
                     s_q.sum[SUM_DROP], s_q.sum[SUM_MISSING],
                     s_q.sum[SUM_CORRUPT], s_q.sum[SUM_PERIPH],
                     s_q.sum[SUM_PROTOCOL], s_q.sum[SUM_BAD_MASTER],
                     s_q.slave_map[7:0], s_q.slave_map[15:8],
                     s_q.slave_map[23:16], s_q.slave_map[31:24],
                     s_q.slave_map[39:32], s_q.slave_map[47:40],
                     s_q.slave_map[55:48], s_q.slave_map[63:56],
                     16'h0000};
  assign rec_w = rec_flat;

  // Bus handshake terms; the ack is registered, so each access takes two cycles.
  assign take    = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign finish  = wb_cyc_i & wb_stb_i & s_q.ack;
  // The clear acts at the edge where the master sees the write acknowledged.
  assign clr_hit = finish & wb_we_i & (word_idx == OFS_CTRL[7:2]) & wb_sel_i[0]
                   & wb_dat_i[CTRL_CLEAR_BIT];

  // Next-state logic for counters, map, interrupt status and bus answer.
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // Counters restart from zero on clear; an event in the same cycle still counts.
      if (clr_hit) begin
        s_d.power_cnt = CNT16_RST;
        s_d.gnd_cnt   = CNT16_RST;
        s_d.sum       = '0;
        s_d.slave_map = MAP_RST;
      end
      // Supply failure counter saturates at its top value.
      if (ev[EV_POWER_FAIL] && s_d.power_cnt != 16'hFFFF) begin
        s_d.power_cnt = s_d.power_cnt + 16'h0001;
      end
      // Ground short counter saturates at its top value.
      if (ev[EV_GND_SHORT] && s_d.gnd_cnt != 16'hFFFF) begin
        s_d.gnd_cnt = s_d.gnd_cnt + 16'h0001;
      end
      // Each summator counts its own event class and saturates.
      for (int i = 0; i < NUM_SUMS; i++) begin
        if (ev[EV_SUM_BASE + i] && s_d.sum[i] != 32'hFFFFFFFF) begin
          s_d.sum[i] = s_d.sum[i] + 32'h00000001;
        end
      end
      // Mark the slave that had an error; marking wins over a clear.
      if (err_valid) begin
        s_d.slave_map[err_idx] = 1'b1;
      end
      // Acknowledge one cycle after taking, and drop it in the cycle after.
      s_d.ack = take;
      if (take) begin
        // Read data is captured when the request is taken; reads change no counter.
        if (wb_we_i) begin
          s_d.dat = 32'h00000000;
        end else if (word_idx < 6'(REC_WORDS)) begin
          s_d.dat = rec_w[4'(REC_WORDS - 1) - word_idx[3:0]];
        end else if (word_idx == OFS_IRQ_STAT[7:2]) begin
          s_d.dat = {24'h000000, s_q.stat};
        end else if (word_idx == OFS_IRQ_MASK[7:2]) begin
          s_d.dat = {24'h000000, s_q.mask};
        end else begin
          // Control and unmapped words read as zero.
          s_d.dat = 32'h00000000;
        end
      end
      // A completed status read clears only the bits it returned.
      if (finish && !wb_we_i && word_idx == OFS_IRQ_STAT[7:2]) begin
        s_d.stat = s_q.stat & ~s_q.dat[NUM_EVENTS-1:0];
      end
      // Mask writes use byte lane 0 and take effect when acknowledged.
      if (finish && wb_we_i && word_idx == OFS_IRQ_MASK[7:2] && wb_sel_i[0]) begin
        s_d.mask = wb_dat_i[NUM_EVENTS-1:0];
      end
      // New events set their sticky bits; setting wins over the read clear.
      s_d.stat = s_d.stat | ev;
      // Level interrupt while any unmasked status bit is set.
      s_d.irq = |(s_d.stat & s_d.mask);
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.power_cnt <= CNT16_RST;
      s_q.gnd_cnt   <= CNT16_RST;
      s_q.sum       <= '0;
      s_q.slave_map <= MAP_RST;
      s_q.stat      <= STAT_RST;
      s_q.mask      <= MASK_RST;
      s_q.ack       <= 1'b0;
      s_q.dat       <= 32'h00000000;
      s_q.irq       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign irq_o    = s_q.irq;

  // Version word reads as zero in its top half.
  a_version_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && take && !wb_we_i && word_idx == 6'h00) |=> (wb_ack_o && wb_dat_o[31:16] == 16'h0000))
    else $error("version bytes not zero");

  // Word 1 returns the ground counter and the dropout high word.
  a_rec_word1: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && take && !wb_we_i && word_idx == 6'h01)
    |=> (wb_dat_o == {$past(s_q.gnd_cnt), $past(s_q.sum[SUM_DROP][31:16])}))
    else $error("record word 1 wrong");

  // Supply failure counts by one.
  a_power_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_power_fail && !clr_hit && s_q.power_cnt != 16'hFFFF)
    |=> (s_q.power_cnt == $past(s_q.power_cnt) + 16'h0001))
    else $error("power fail counter did not step");

  // Ground short counts by one.
  a_gnd_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_gnd_short && !clr_hit && s_q.gnd_cnt != 16'hFFFF)
    |=> (s_q.gnd_cnt == $past(s_q.gnd_cnt) + 16'h0001))
    else $error("ground short counter did not step");

  // Dropout summator holds without its event.
  a_drop_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!ev_slave_drop && !clr_hit) |=> $stable(s_q.sum[SUM_DROP]))
    else $error("dropout summator moved without event");

  // Missing response summator counts by one.
  a_miss_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_missing && !clr_hit && s_q.sum[SUM_MISSING] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_MISSING] == $past(s_q.sum[SUM_MISSING]) + 32'h00000001))
    else $error("missing summator did not step");

  // Corrupt response summator counts by one.
  a_corrupt_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_corrupt && !clr_hit && s_q.sum[SUM_CORRUPT] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_CORRUPT] == $past(s_q.sum[SUM_CORRUPT]) + 32'h00000001))
    else $error("corrupt summator did not step");

  // Peripheral fault summator counts by one.
  a_periph_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_periph && !clr_hit && s_q.sum[SUM_PERIPH] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_PERIPH] == $past(s_q.sum[SUM_PERIPH]) + 32'h00000001))
    else $error("peripheral summator did not step");

  // Protocol error summator counts by one.
  a_proto_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_protocol && !clr_hit && s_q.sum[SUM_PROTOCOL] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_PROTOCOL] == $past(s_q.sum[SUM_PROTOCOL]) + 32'h00000001))
    else $error("protocol summator did not step");

  // Bad own frame summator counts by one.
  a_badm_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_bad_master && !clr_hit && s_q.sum[SUM_BAD_MASTER] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_BAD_MASTER] == $past(s_q.sum[SUM_BAD_MASTER]) + 32'h00000001))
    else $error("bad master summator did not step");

  // A marked slave shows in the map at the next edge.
  a_map_set: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && err_valid) |=> s_q.slave_map[$past(err_idx)])
    else $error("slave map bit not set");

  // A clear with no events leaves all counters zero.
  a_clear_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && clr_hit && ev == 8'h00 && !err_valid)
    |=> (s_q.power_cnt == 16'h0000 && s_q.gnd_cnt == 16'h0000 && s_q.sum == '0
         && s_q.slave_map == 64'h0000000000000000))
    else $error("clear left counters nonzero");

  // A completed read leaves the supply failure counter and the summators untouched.
  a_read_keeps: assert property (
    @(posedge clk) disable iff (!nrst)
    (finish && !wb_we_i && ev == 8'h00) |=> ($stable(s_q.power_cnt) && $stable(s_q.sum)))
    else $error("read changed a counter");

  // The acknowledge is a single-cycle pulse.
  a_ack_pulse: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Dropout summator counts by one.
  a_drop_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev_slave_drop && !clr_hit && s_q.sum[SUM_DROP] != 32'hFFFFFFFF)
    |=> (s_q.sum[SUM_DROP] == $past(s_q.sum[SUM_DROP]) + 32'h00000001))
    else $error("dropout summator did not step");

  // Supply failure counter holds without its event.
  a_power_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!ev_power_fail && !clr_hit) |=> $stable(s_q.power_cnt))
    else $error("power fail counter moved without event");

  // Ground short counter holds without its event.
  a_gnd_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!ev_gnd_short && !clr_hit) |=> $stable(s_q.gnd_cnt))
    else $error("ground short counter moved without event");

  // Slave map holds without a mark or a clear.
  a_map_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (!err_valid && !clr_hit) |=> $stable(s_q.slave_map))
    else $error("slave map moved without a mark");

  // Word 0 returns the supply failure count in its low half.
  a_rec_word0: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && take && !wb_we_i && word_idx == 6'h00)
    |=> (wb_dat_o[15:0] == $past(s_q.power_cnt)))
    else $error("record word 0 wrong");

  // Word 8 returns the last A map bytes and the first B map bytes.
  a_map_word8: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && take && !wb_we_i && word_idx == 6'h08)
    |=> (wb_dat_o == {$past(s_q.slave_map[23:16]), $past(s_q.slave_map[31:24]),
                      $past(s_q.slave_map[39:32]), $past(s_q.slave_map[47:40])}))
    else $error("record word 8 wrong");

  // A taken request is acknowledged at the next edge.
  a_ack_answer: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && take) |=> wb_ack_o)
    else $error("request not acknowledged");

  // Every event sets its sticky status bit at the edge where it is seen.
  a_stat_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && ev != 8'h00) |=> ((s_q.stat & $past(ev)) == $past(ev)))
    else $error("event did not set its status bit");

  // The interrupt is high exactly while an unmasked status bit is set.
  a_irq_level: assert property (
    @(posedge clk) disable iff (!nrst)
    irq_o == |(s_q.stat & s_q.mask))
    else $error("interrupt level disagrees with status and mask");

  // A low clock enable freezes the whole state.
  a_ce_freeze: assert property (
    @(posedge clk) disable iff (!nrst)
    !ce |=> $stable(s_q))
    else $error("state moved with clock enable low");

  // An acknowledged mask write lands in the mask register.
  a_mask_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && finish && wb_we_i && word_idx == OFS_IRQ_MASK[7:2] && wb_sel_i[0])
    |=> (s_q.mask == $past(wb_dat_i[NUM_EVENTS-1:0])))
    else $error("mask write lost");
endmodule
`default_nettype wire

//--- testbench/lec_io_ctrl.sv
// Wishbone classic master model standing in for the controller that reads the record.
`default_nettype none
module lec_io_ctrl (
  // Clock.
  input  wire logic        clk,
  // Wishbone classic master side.
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [7:0]  adr,
  output var  logic [3:0]  sel,
  output var  logic [31:0] wdat,
  input  wire logic        ack,
  input  wire logic [31:0] rdat
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus is idle from time zero on.
  initial begin
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    adr  <= 8'h00;
    sel  <= 4'h0;
    wdat <= 32'h00000000;
  end
  // One classic cycle; the request stands until ack is seen at a rising edge.
  // The first edge leaves at least one idle cycle after the previous transfer.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    n = 0;
    // The wait is bounded so that a silent slave cannot hang the run.
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    ok = (ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench for the line error counter readout block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lec_pkg::*;
  // Clock, reset and block signals.
  logic        clk, nrst, ce, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  ev;
  logic        err_valid, err_bank_b;
  logic [4:0]  err_slave;
  // Expected record bytes and the score.
  logic [7:0]  rb [0:39];
  int          fail_count, n_tests;

  lec_io_ctrl ctl (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
                   .wdat(wdat), .ack(ack), .rdat(rdat));
  lec_readout DUT (.clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .ev_power_fail(ev[0]), .ev_gnd_short(ev[1]),
    .ev_slave_drop(ev[2]), .ev_missing(ev[3]), .ev_corrupt(ev[4]), .ev_periph(ev[5]),
    .ev_protocol(ev[6]), .ev_bad_master(ev[7]), .err_valid(err_valid),
    .err_bank_b(err_bank_b), .err_slave(err_slave));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      fail_count++;
    end
  endtask
  // One bus transfer; a missing acknowledge ends the run.
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    ctl.xfer(w, a, d, q, ok);
    if (!ok) begin
      $display("mismatch at %0t: no acknowledge", $time);
      fail_count++;
      summarize();
    end
  endtask
  // Reads all record words and compares them with the expected bytes, high byte first.
  task automatic check_record();
    for (int k = 0; k < 10; k++) begin
      access(1'b0, 8'(4 * k), 32'h00000000);
      check(q, {rb[4*k], rb[4*k+1], rb[4*k+2], rb[4*k+3]}, "record word");
    end
  endtask
  // Raises the given event inputs for one cycle.
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  // Marks one slave as faulty for one cycle.
  task automatic mark(input logic b, input logic [4:0] s);
    @(posedge clk);
    err_valid  <= 1'b1;
    err_bank_b <= b;
    err_slave  <= s;
    @(posedge clk);
    err_valid  <= 1'b0;
  endtask
  // After reset the whole record, version included, reads zero.
  task automatic t_reset();
    foreach (rb[i]) rb[i] = 8'h00;
    check_record();
  endtask
  // Event class i fires i+1 times; each counter lands in its own bytes.
  task automatic t_counts();
    for (int i = 0; i < 8; i++) repeat (i + 1) pulse(8'h01 << i);
    {rb[2], rb[3]} = 16'h0001;
    {rb[4], rb[5]} = 16'h0002;
    for (int s = 0; s < 6; s++) {rb[6+4*s], rb[7+4*s], rb[8+4*s], rb[9+4*s]} = 32'(s + 3);
    check_record();
    check_record();
  endtask
  // Slaves 0, 31 and 9 of bank A and slaves 5 and 24 of bank B set their own map bits.
  task automatic t_map();
    mark(1'b0, 5'd0);
    mark(1'b0, 5'd31);
    mark(1'b0, 5'd9);
    mark(1'b1, 5'd5);
    mark(1'b1, 5'd24);
    rb[30] = 8'h01;
    rb[31] = 8'h02;
    rb[33] = 8'h80;
    rb[34] = 8'h20;
    rb[37] = 8'h01;
    check_record();
  endtask
  // With the clock enable low, events and marks leave every count as it was.
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pulse(8'hFF);
    mark(1'b0, 5'd3);
    @(posedge clk);
    ce <= 1'b1;
    check_record();
  endtask
  // Writes to the record are ignored, the clear command zeroes it, unmapped reads zero.
  task automatic t_clear();
    access(1'b1, OFS_REC_FIRST, 32'hFFFFFFFF);
    access(1'b0, OFS_REC_FIRST, 32'h00000000);
    check(q, {rb[0], rb[1], rb[2], rb[3]}, "record after write");
    access(1'b1, OFS_CTRL, 32'h00000001);
    foreach (rb[i]) rb[i] = 8'h00;
    check_record();
    access(1'b0, 8'hFC, 32'h00000000);
    check(q, 32'h00000000, "unmapped read");
  endtask
  // Sticky status, read clearing, mask and the interrupt level.
  task automatic t_irq();
    access(1'b0, OFS_IRQ_STAT, 32'h00000000);
    check(q, 32'h000000FF, "status after all events");
    access(1'b0, OFS_IRQ_STAT, 32'h00000000);
    check(q, 32'h00000000, "status after read");
    access(1'b1, OFS_IRQ_MASK, 32'h00000002);
    pulse(8'h02);
    @(posedge clk);
    check({31'h0, irq}, 32'h00000001, "irq with unmasked event");
    access(1'b0, OFS_IRQ_STAT, 32'h00000000);
    check(q, 32'h00000002, "status of ground short");
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h00000000, "irq after status read");
    pulse(8'h01);
    @(posedge clk);
    check({31'h0, irq}, 32'h00000000, "irq with masked event");
    access(1'b0, OFS_REC_FIRST, 32'h00000000);
    check(q, 32'h00000001, "supply count after clear");
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    fail_count = 0;
    n_tests    = 0;
    nrst       <= 1'b0;
    ce         <= 1'b1;
    ev         <= 8'h00;
    err_valid  <= 1'b0;
    err_bank_b <= 1'b0;
    err_slave  <= 5'd0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_counts();
    t_map();
    t_freeze();
    t_clear();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
